/* File: rtl/ioe_pkg.sv */
// Purpose: shared constants and types for the output-enable path block
// Assumes: one clock clk_i at 250 MHz, register bus is AHB-Lite, 32-bit words
// Notes:   offsets are byte addresses of aligned words
package ioe_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_DELAY  = 8'h04;
   localparam logic [7:0] ADDR_OE     = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_FIFO   = 8'h10;
   localparam logic [7:0] ADDR_IDATA  = 8'h14;
   // ctrl field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_IMODE    = 2;
   localparam int CTRL_CLR      = 3;
   localparam int CTRL_PRE      = 4;
   // delay field positions and ranges
   localparam int DLY_IN_LSB  = 0;
   localparam int DLY_OUT_LSB = 8;
   localparam int DLY_OE_LSB  = 12;
   localparam logic [5:0] DLY_IN_MAX  = 6'h3f;
   localparam logic [3:0] DLY_OUT_MAX = 4'hf;
   // reset values
   localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
   localparam logic [31:0] DELAY_RST = 32'h0000_0000;
   // device figures
   localparam int OE_GROUPS = 2;
   localparam int PINS      = 8;
   localparam int FIFO_DEPTH = 16;
   // output-enable register modes
   typedef enum logic [1:0] {
      IOE_BYPASS,
      IOE_PACKED,
      IOE_HALF_RATE
   } ioe_mode_type;
endpackage

/* File: rtl/ioe_fifo_if.sv */
// Purpose: valid/ready stream carrier between the top and its fifo
// Assumes: single clock
// Notes:   word width set by parameter
interface ioe_fifo_if #(parameter int W = 32);
   logic         in_valid;
   logic         in_ready;
   logic [W-1:0] in_data;
   logic         out_valid;
   logic         out_ready;
   logic [W-1:0] out_data;
   modport src  (output in_valid, in_data, input in_ready,
                 output out_ready, input out_valid, out_data);
   modport fifo (input in_valid, in_data, output in_ready,
                 input out_ready, output out_valid, out_data);
endinterface

/* File: rtl/ioe_fifo.sv */
// Purpose: small synchronous fifo, registered read data
// Assumes: single clock, asynchronous active-low reset
// Notes:   depth must be a power of two
module ioe_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = 16
) (
   input wire logic clk_i,      // clock
   input wire logic rst_n_i,    // async reset, low
   ioe_fifo_if.fifo f           // stream ports
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_r [DEPTH];
   logic [AW:0]  wr_r;
   logic [AW:0]  rd_r;
   logic         full;
   logic         empty;
   logic         push;
   logic         pop;
   logic         ov_r;
   logic [W-1:0] od_r;

   // pointers carry one wrap bit so full and empty are exact
   assign empty = (wr_r == rd_r);
   assign full  = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
   assign f.in_ready = !full;
   assign push = f.in_valid && !full;
   assign pop  = !empty && (!ov_r || f.out_ready);
   assign f.out_valid = ov_r;
   assign f.out_data  = od_r;

   // storage, no reset needed
   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem_r[wr_r[AW-1:0]] <= f.in_data;
      end
   end

   // pointers
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wr_r <= '0;
         rd_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_r <= wr_r + 1'b1;
         end
         if (pop)
         begin
            rd_r <= rd_r + 1'b1;
         end
      end
   end

   // output register stage
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ov_r <= 1'b0;
         od_r <= '0;
      end
      else if (pop)
      begin
         ov_r <= 1'b1;
         od_r <= mem_r[rd_r[AW-1:0]];
      end
      else if (f.out_ready)
      begin
         ov_r <= 1'b0;
      end
   end
endmodule

/* File: rtl/ioe_top.sv */
// Purpose: output-enable path of a general purpose i/o group, with delays
// Assumes: clk_i is the full-rate clock; half rate is an enable every 2nd cycle
// Notes:   enable words queue in a 16-word fifo and drain one per half-rate slot
//
// Functional notes
// - the enable path has no true double-rate stage at full rate, only a packable register.
// - a single-edge register clocked by the full-rate clock sits in the full-rate position.
// - there is exactly one half-rate conversion stage in the enable path.
// - three modes are selectable: bypass, packed register and half-rate single-rate output.
// - in bypass the core enable reaches the delay element with no register in between.
// - the eight pins of a bank share only two independent output enables.
// - the full-rate stage of the data paths can act as a plain single-edge flip-flop.
// - the input delay takes settings 0 to 63, scaling linearly with the setting.
// - the output and enable delays each take settings 0 to 15.
// - the full-rate input stage captures pad data on the rising edge only; the second register takes that sample one cycle later.
// - every double-rate stage uses the same shared clear and preset.
//
// Local design decisions: the AHB-Lite register port and the register addresses.
module ioe_top (
   input  wire logic        clk_i,     // full-rate clock
   input  wire logic        rst_n_i,   // async reset, low
   input  wire logic        hsel,      // ahb select
   input  wire logic [31:0] haddr,     // ahb address
   input  wire logic [1:0]  htrans,    // ahb transfer type
   input  wire logic        hwrite,    // ahb write
   input  wire logic [2:0]  hsize,     // ahb size
   input  wire logic [31:0] hwdata,    // ahb write data
   input  wire logic        hready,    // ahb bus ready
   output logic      [31:0] hrdata,    // ahb read data
   output logic             hreadyout, // ahb slave ready
   output logic             hresp,     // ahb response, always okay
   input  wire logic [1:0]  oe_core_i, // core enables, one per group
   input  wire logic [7:0]  dout_i,    // core output data
   input  wire logic [7:0]  pad_i,     // pad input levels
   output logic      [7:0]  pad_o,     // pad output levels
   output logic      [7:0]  pad_oe_n_o // pad enable, low drives
);
   localparam int DW = ioe_pkg::OE_GROUPS;

   logic [31:0] ctrl_r;
   logic [31:0] delay_r;
   logic        wr_pend_r;
   logic        rd_pend_r;
   logic [7:0]  addr_r;
   logic        hr_en_r;
   logic [DW-1:0] oe_full_r;
   logic [DW-1:0] oe_half_r;
   logic [DW-1:0] oe_sel;
   logic [DW-1:0] oe_dly;
   logic [7:0]  dout_r;
   logic [7:0]  dout_sel;
   logic [7:0]  din_rise_r;
   logic [7:0]  din_fall_r;
   logic [7:0]  din_sdr_r;
   logic [3:0]  oe_cnt_r [DW];
   logic [DW-1:0] oe_dly_r;
   logic [3:0]  out_cnt_r [8];
   logic [7:0]  out_dly_r;
   logic [5:0]  in_cnt_r [8];
   logic [7:0]  in_dly_r;
   logic        clr;
   logic        pre;
   ioe_pkg::ioe_mode_type mode;
   logic        ahb_go;

   ioe_fifo_if #(.W(DW)) q ();

   ioe_fifo #(.W(DW), .DEPTH(ioe_pkg::FIFO_DEPTH)) u_fifo (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .f       (q.fifo)
   );

   // mode decode; an illegal code falls back to bypass
   always_comb
   begin
      unique case (ctrl_r[ioe_pkg::CTRL_MODE_LSB +: 2])
         2'h1:    mode = ioe_pkg::IOE_PACKED;
         2'h2:    mode = ioe_pkg::IOE_HALF_RATE;
         default: mode = ioe_pkg::IOE_BYPASS;
      endcase
   end

   // one shared clear and preset for all double-rate stages
   assign clr = ctrl_r[ioe_pkg::CTRL_CLR];
   assign pre = ctrl_r[ioe_pkg::CTRL_PRE];

   // bus slave: zero wait states, okay always
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign ahb_go    = hsel && hready && htrans[1];

   // address phase capture
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         addr_r    <= 8'h00;
      end
      else if (hready)
      begin
         wr_pend_r <= ahb_go && hwrite;
         rd_pend_r <= ahb_go && !hwrite;
         addr_r    <= haddr[7:0];
      end
   end

   // control and delay registers, written in the data phase
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ctrl_r  <= ioe_pkg::CTRL_RST;
         delay_r <= ioe_pkg::DELAY_RST;
      end
      else if (wr_pend_r)
      begin
         if (addr_r == ioe_pkg::ADDR_CTRL)
         begin
            ctrl_r <= {27'h0, hwdata[4:0]};
         end
         if (addr_r == ioe_pkg::ADDR_DELAY)
         begin
            // only legal widths are kept: 0..63 in, 0..15 out and enable
            delay_r <= {16'h0, hwdata[15:12], hwdata[11:8], 2'h0, hwdata[5:0]};
         end
      end
   end

   // queued enable words come from writes to the fifo window
   assign q.in_valid = wr_pend_r && (addr_r == ioe_pkg::ADDR_FIFO);
   assign q.in_data  = hwdata[DW-1:0];

   // read mux; unmapped words read zero
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         hrdata <= 32'h0000_0000;
      end
      else if (ahb_go && !hwrite)
      begin
         unique case (haddr[7:0])
            ioe_pkg::ADDR_CTRL:   hrdata <= ctrl_r;
            ioe_pkg::ADDR_DELAY:  hrdata <= delay_r;
            ioe_pkg::ADDR_OE:     hrdata <= {30'h0, oe_dly_r};
            ioe_pkg::ADDR_STATUS: hrdata <= {29'h0, q.out_valid, !q.in_ready, hr_en_r};
            ioe_pkg::ADDR_IDATA:  hrdata <= {16'h0, din_fall_r, din_rise_r};
            default:              hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // half-rate enable: exactly every second full-rate cycle
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         hr_en_r <= 1'b0;
      end
      else
      begin
         hr_en_r <= !hr_en_r;
      end
   end

   // the single half-rate stage drains one fifo word per half-rate slot
   assign q.out_ready = hr_en_r && (mode == ioe_pkg::IOE_HALF_RATE);
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         oe_half_r <= '0;
      end
      else if (clr)
      begin
         oe_half_r <= '0;
      end
      else if (pre)
      begin
         oe_half_r <= '1;
      end
      else if (q.out_ready && q.out_valid)
      begin
         oe_half_r <= q.out_data;
      end
   end

   // full-rate position is a plain single-edge register, so it packs
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         oe_full_r <= '0;
      end
      else if (clr)
      begin
         oe_full_r <= '0;
      end
      else if (pre)
      begin
         oe_full_r <= '1;
      end
      else if (mode == ioe_pkg::IOE_HALF_RATE)
      begin
         oe_full_r <= oe_half_r;
      end
      else
      begin
         oe_full_r <= oe_core_i;
      end
   end

   // mode select in front of the enable delay element
   always_comb
   begin
      unique case (mode)
         ioe_pkg::IOE_BYPASS: oe_sel = oe_core_i;
         ioe_pkg::IOE_PACKED: oe_sel = oe_full_r;
         default:             oe_sel = oe_full_r;
      endcase
   end

   // output data full-rate stage as a plain flip-flop in every mode except bypass
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         dout_r <= 8'h00;
      end
      else if (clr)
      begin
         dout_r <= 8'h00;
      end
      else if (pre)
      begin
         dout_r <= 8'hff;
      end
      else
      begin
         dout_r <= dout_i;
      end
   end
   assign dout_sel = (mode == ioe_pkg::IOE_BYPASS) ? dout_i : dout_r;

   // input stage: CTRL_IMODE picks which of the two captures feeds the single-rate register
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         din_rise_r <= 8'h00;
         din_sdr_r  <= 8'h00;
      end
      else if (clr)
      begin
         din_rise_r <= 8'h00;
         din_sdr_r  <= 8'h00;
      end
      else
      begin
         din_rise_r <= pre ? 8'hff : in_dly_r;
         din_sdr_r  <= ctrl_r[ioe_pkg::CTRL_IMODE] ? din_fall_r : din_rise_r;
      end
   end

   // second half of the capture pair; clock is single edge so it takes the
   // delayed sample one cycle later, a limitation of one-clock modelling
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         din_fall_r <= 8'h00;
      end
      else if (clr)
      begin
         din_fall_r <= 8'h00;
      end
      else
      begin
         din_fall_r <= pre ? 8'hff : din_rise_r;
      end
   end

   // enable delay elements: a change reaches oe_dly_r the setting plus one cycles later
   genvar g;
   generate
      for (g = 0; g < DW; g++)
      begin : g_oe
         always_ff @(posedge clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               oe_cnt_r[g] <= 4'h0;
               oe_dly_r[g] <= 1'b0;
            end
            else if (oe_sel[g] == oe_dly_r[g])
            begin
               oe_cnt_r[g] <= 4'h0;
            end
            else if (oe_cnt_r[g] >= delay_r[ioe_pkg::DLY_OE_LSB +: 4])
            begin
               oe_dly_r[g] <= oe_sel[g];
               oe_cnt_r[g] <= 4'h0;
            end
            else
            begin
               oe_cnt_r[g] <= oe_cnt_r[g] + 4'h1;
            end
         end
      end
   endgenerate
   assign oe_dly = oe_dly_r;

   // per-pin output and input delay elements
   genvar p;
   generate
      for (p = 0; p < ioe_pkg::PINS; p++)
      begin : g_pin
         always_ff @(posedge clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               out_cnt_r[p] <= 4'h0;
               out_dly_r[p] <= 1'b0;
            end
            else if (dout_sel[p] == out_dly_r[p])
            begin
               out_cnt_r[p] <= 4'h0;
            end
            else if (out_cnt_r[p] >= delay_r[ioe_pkg::DLY_OUT_LSB +: 4])
            begin
               out_dly_r[p] <= dout_sel[p];
               out_cnt_r[p] <= 4'h0;
            end
            else
            begin
               out_cnt_r[p] <= out_cnt_r[p] + 4'h1;
            end
         end

         // delay grows linearly with the setting, 1 to 64 cycles
         always_ff @(posedge clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               in_cnt_r[p] <= 6'h00;
               in_dly_r[p] <= 1'b0;
            end
            else if (pad_i[p] == in_dly_r[p])
            begin
               in_cnt_r[p] <= 6'h00;
            end
            else if (in_cnt_r[p] >= delay_r[ioe_pkg::DLY_IN_LSB +: 6])
            begin
               in_dly_r[p] <= pad_i[p];
               in_cnt_r[p] <= 6'h00;
            end
            else
            begin
               in_cnt_r[p] <= in_cnt_r[p] + 6'h01;
            end
         end

         // pins 0-3 share enable 0, pins 4-7 enable 1
         assign pad_oe_n_o[p] = !oe_dly[p / (ioe_pkg::PINS / DW)];
         assign pad_o[p]      = out_dly_r[p];
      end
   endgenerate
endmodule

/* File: tb/ioe_checker.sv */
// Purpose: port-level checks of the enable path and its register bus
// Assumes: enable delay and mode are learned by watching bus writes
// Notes:   latency checks hold only while the snooped enable delay is zero; oe_delay_a covers any delay
module ioe_checker (
   input wire logic        clk_i,      // clock
   input wire logic        rst_n_i,    // async reset, low
   input wire logic        hsel,       // ahb select
   input wire logic [31:0] haddr,      // ahb address
   input wire logic [1:0]  htrans,     // ahb transfer type
   input wire logic        hwrite,     // ahb write
   input wire logic [31:0] hwdata,     // ahb write data
   input wire logic        hready,     // ahb bus ready
   input wire logic [31:0] hrdata,     // ahb read data
   input wire logic        hreadyout,  // ahb slave ready
   input wire logic        hresp,      // ahb response
   input wire logic [1:0]  oe_core_i,  // core enables
   input wire logic [7:0]  pad_oe_n_o  // pad enables, low drives
);
   logic       p_r;    // data phase pending
   logic       w_r;    // pending is a write
   logic [7:0] a_r;    // pending address
   logic [1:0] mode_r; // snooped mode
   logic       cp_r;   // snooped clear or preset
   logic [3:0] dly_r;  // snooped enable delay
   logic [4:0] cnt_r;  // edges the enable input has held
   logic       last_r; // enable input at last edge
   logic       byp;
   logic       pk;
   logic       hr;
   logic       dz;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // shadow of mode and delay, taken at the same edge the block stores them
   always_ff @(posedge clk_i or negedge rst_n_i)
      if (!rst_n_i)
      begin
         p_r    <= 1'b0;
         w_r    <= 1'b0;
         a_r    <= 8'h00;
         mode_r <= 2'h0;
         cp_r   <= 1'b0;
         dly_r  <= 4'h0;
      end
      else
      begin
         p_r <= hsel && hready && htrans[1];
         w_r <= hwrite;
         a_r <= haddr[7:0];
         if (p_r && w_r && a_r == ioe_pkg::ADDR_CTRL)
         begin
            mode_r <= hwdata[1:0];
            cp_r   <= |hwdata[4:3]; // clear or preset overrides the registered stages
         end
         if (p_r && w_r && a_r == ioe_pkg::ADDR_DELAY)
            dly_r <= hwdata[15:12];
      end

   // saturating count, so a long quiet spell never wraps into a false short one
   always_ff @(posedge clk_i or negedge rst_n_i)
      if (!rst_n_i)
      begin
         cnt_r  <= 5'h1f;
         last_r <= 1'b0;
      end
      else
      begin
         cnt_r  <= (oe_core_i[0] != last_r) ? 5'h00 : cnt_r + {4'h0, cnt_r != 5'h1f};
         last_r <= oe_core_i[0];
      end

   assign byp = (mode_r == 2'h0) || (mode_r == 2'h3);
   // the timing checks of the registered modes stand aside while clear or preset holds
   assign pk  = (mode_r == 2'h1) && !cp_r;
   assign hr  = (mode_r == 2'h2) && !cp_r;
   assign dz  = dly_r == 4'h0;

   ready_high_a: assert property (hreadyout == 1'b1)
      else $error("slave ready dropped");
   resp_okay_a: assert property (hresp == 1'b0)
      else $error("error response seen");
   rd_unmapped_a: assert property (hsel && hready && htrans[1] && !hwrite &&
      haddr[31:8] == 24'h0 && haddr[7:0] >= 8'h18 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   group_share_a: assert property (
      pad_oe_n_o[3:0] inside {4'h0, 4'hf} && pad_oe_n_o[7:4] inside {4'h0, 4'hf})
      else $error("pins of one group disagree");
   bypass_comb_a: assert property (
      byp && dz |=> pad_oe_n_o[0] == !$past(oe_core_i[0]))
      else $error("bypass enable late or wrong");
   packed_reg_a: assert property (
      pk && dz ##1 pk && dz |=> pad_oe_n_o[0] == !$past(oe_core_i[0], 2))
      else $error("packed enable not one register");
   half_slow_a: assert property (
      (hr && dz) [*3] ##1 (hr && dz && $changed(pad_oe_n_o[0])) |=> $stable(pad_oe_n_o[0]))
      else $error("half-rate enable moved twice in a row");
   oe_delay_a: assert property (
      byp && $past(byp) && $changed(pad_oe_n_o[0]) |-> cnt_r >= {1'b0, dly_r})
      else $error("enable moved before its delay ran out");

   cover property (byp && $changed(pad_oe_n_o));
   cover property (pk && $changed(pad_oe_n_o));
   cover property (hr && $changed(pad_oe_n_o));
endmodule

bind ioe_top ioe_checker ioe_checker_i (.clk_i, .rst_n_i, .hsel, .haddr, .htrans, .hwrite,
   .hwdata, .hready, .hrdata, .hreadyout, .hresp, .oe_core_i, .pad_oe_n_o);

/* File: tb/ioe_pad_model.sv */
// Purpose: pad wire between the block's buffer and a far device
// Assumes: weak pull-up on every pad
// Notes:   the block wins wherever its enable is low
module ioe_pad_model (
   input  wire logic [7:0] pad_o,      // block levels
   input  wire logic [7:0] pad_oe_n_o, // block enables, low drives
   input  wire logic [7:0] ext_lvl_i,  // far device levels
   input  wire logic [7:0] ext_en_i,   // far device drives, high
   output logic      [7:0] pad_i       // resolved pad levels
);
   // a pad released by both sides floats to the pull-up, never keeps the last driven level
   always_comb
      for (int k = 0; k < 8; k++)
         pad_i[k] = !pad_oe_n_o[k] ? pad_o[k] : (ext_en_i[k] ? ext_lvl_i[k] : 1'b1);
endmodule

/* File: tb/ioe_top_tb_top.sv */
// Purpose: self-checking bench of the enable path block
// Assumes: half rate is an internal slot enable, so one clock serves
// Notes:   fixed seed; random enables and levels mixed with corner cases
module ioe_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i        = 1'b0;
   logic        rst_n_i      = 1'b0;
   logic        hsel         = 1'b0;
   logic [31:0] haddr        = 32'h0;
   logic [1:0]  htrans       = 2'h0;
   logic        hwrite       = 1'b0;
   logic [31:0] hwdata       = 32'h0;
   logic        hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [1:0]  oe_core_i    = 2'h0;
   logic [7:0]  dout_i       = 8'h0;
   logic [7:0]  pad_i;
   logic [7:0]  pad_o;
   logic [7:0]  pad_oe_n_o;
   logic [7:0]  ext_lvl      = 8'h0;
   logic [7:0]  ext_en       = 8'h0;
   logic [1:0]  cur          = 2'h0;
   logic [31:0] rd;
   logic [31:0] r;
   logic [7:0]  last_pad;
   logic        mon          = 1'b0;
   int          seed         = 32'hd237;
   int          idx          = 0;
   int          gap          = 0;
   int          n_errors     = 0;
   int          total_checks = 0;

   always #2 clk_i = ~clk_i;
   assign hready = hreadyout;

   ioe_top ioe_top_i (.clk_i, .rst_n_i, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready, .hrdata, .hreadyout, .hresp, .oe_core_i, .dout_i, .pad_i, .pad_o,
      .pad_oe_n_o);
   ioe_pad_model ioe_pad_model_i (.pad_o, .pad_oe_n_o, .ext_lvl_i(ext_lvl), .ext_en_i(ext_en),
      .pad_i);

   function automatic logic [31:0] exp_oe(input logic [1:0] v);
      return {24'h0, {4{~v[1]}}, {4{~v[0]}}};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one word transfer; holds each phase until ready is seen at an edge
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge clk_i);
      while (hready !== 1'b1)
         @(posedge clk_i);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk_i);
      while (hready !== 1'b1)
         @(posedge clk_i);
      rd = hrdata;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(a, 1'b0, 32'h0);
      chk(rd & m, e);
   endtask

   // new enable must be absent one edge early and present exactly n edges on
   task automatic oe_step(input logic [1:0] v, input int n);
      oe_core_i <= v;
      repeat (n - 1)
         @(posedge clk_i);
      chk({24'h0, pad_oe_n_o}, exp_oe(cur));
      @(posedge clk_i);
      chk({24'h0, pad_oe_n_o}, exp_oe(v));
      cur = v;
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // half-rate watcher: each pad change is the next queued word, in order
   always @(posedge clk_i)
      if (mon)
      begin
         if (pad_oe_n_o !== last_pad)
         begin
            chk({24'h0, pad_oe_n_o}, exp_oe(2'(idx + 1)));
            if (idx > 0)
               chk(32'(gap), 32'd2);
            idx++;
            gap = 0;
         end
         gap++;
         last_pad = pad_oe_n_o;
      end

   initial
   begin
      #40000;
      n_errors++;
      $display("watchdog expired");
      stop_test();
   end

   initial
   begin
      repeat (12)
         @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      chk({24'h0, pad_oe_n_o}, 32'hff);
      rdchk(ioe_pkg::ADDR_CTRL, 32'h1f, ioe_pkg::CTRL_RST);
      rdchk(ioe_pkg::ADDR_DELAY, 32'hff3f, ioe_pkg::DELAY_RST);
      bus(8'h18, 1'b1, 32'hffff_ffff);
      rdchk(8'h18, 32'hffff_ffff, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         r = (i == 0) ? 32'hff3f : $random(seed) & 32'hff3f;
         bus(ioe_pkg::ADDR_DELAY, 1'b1, r);
         rdchk(ioe_pkg::ADDR_DELAY, 32'hff3f, r);
      end
      bus(ioe_pkg::ADDR_DELAY, 1'b1, 32'h0);
      $display("test registers done");
      // bypass, packed, bypass alias; half rate has its own test
      for (int m = 0; m < 4; m++)
         if (m != 2)
         begin
            bus(ioe_pkg::ADDR_CTRL, 1'b1, 32'(m));
            repeat (3)
               @(posedge clk_i);
            for (int i = 0; i < 8; i++)
               oe_step(2'($random(seed)), (m == 1) ? 3 : 2);
         end
      $display("test modes done");
      bus(ioe_pkg::ADDR_CTRL, 1'b1, 32'h0);
      bus(ioe_pkg::ADDR_DELAY, 1'b1, 32'hf000);
      oe_step(~cur, 17);
      oe_core_i <= ~cur;
      repeat (5)
         @(posedge clk_i);
      oe_core_i <= cur;
      repeat (22)
      begin
         @(posedge clk_i);
         chk({24'h0, pad_oe_n_o}, exp_oe(cur));
      end
      bus(ioe_pkg::ADDR_DELAY, 1'b1, 32'h0);
      $display("test delay done");
      oe_step(2'h0, 2);
      ext_en <= 8'hff;
      for (int i = 0; i < 3; i++)
      begin
         ext_lvl <= 8'($random(seed));
         repeat (6)
            @(posedge clk_i);
         rdchk(ioe_pkg::ADDR_IDATA, 32'hffff, {16'h0, ext_lvl, ext_lvl});
      end
      ext_en <= 8'h00;
      oe_step(2'h3, 2);
      dout_i <= 8'($random(seed));
      repeat (6)
         @(posedge clk_i);
      chk({24'h0, pad_o}, {24'h0, dout_i});
      rdchk(ioe_pkg::ADDR_IDATA, 32'hff, {24'h0, dout_i});
      // bypass has no register to clear, so clear and preset are seen in packed mode;
      // clear comes last so the half-rate stage starts from zero
      bus(ioe_pkg::ADDR_CTRL, 1'b1, 32'h11);
      repeat (3)
         @(posedge clk_i);
      chk({24'h0, pad_o}, 32'hff);
      bus(ioe_pkg::ADDR_CTRL, 1'b1, 32'h19);
      repeat (3)
         @(posedge clk_i);
      chk({24'h0, pad_o}, 32'h0);
      bus(ioe_pkg::ADDR_CTRL, 1'b1, 32'h0);
      repeat (2)
         @(posedge clk_i);
      $display("test pads done");
      // fill past full while the drain is stalled: 16 words in store and one in the
      // output stage fit, so the 18th write must vanish
      oe_step(2'h0, 2);
      for (int i = 0; i < 18; i++)
         bus(ioe_pkg::ADDR_FIFO, 1'b1, (i == 17) ? 32'h3 : 32'(2'(i + 1)));
      rdchk(ioe_pkg::ADDR_STATUS, 32'h6, 32'h6);
      last_pad = pad_oe_n_o;
      mon = 1'b1;
      bus(ioe_pkg::ADDR_CTRL, 1'b1, 32'h2);
      repeat (80)
         @(posedge clk_i);
      mon = 1'b0;
      chk(32'(idx), 32'd17);
      rdchk(ioe_pkg::ADDR_STATUS, 32'h4, 32'h0);
      $display("test half rate done");
      stop_test();
   end
endmodule
